// >>> common/spectral_pkg.sv
// shared constants, types and helpers of the sensor register bank
// assumes byte-wide register access and a 100 MHz system clock
package spectral_pkg;

  localparam logic [7:0] ADDR_HW_HI = 8'h00;
  localparam logic [7:0] ADDR_HW_LO = 8'h01;
  localparam logic [7:0] ADDR_FW_HI = 8'h02;
  localparam logic [7:0] ADDR_FW_LO = 8'h03;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_INTEG = 8'h05;
  localparam logic [7:0] ADDR_TEMP = 8'h06;
  localparam logic [7:0] ADDR_LED = 8'h07;
  localparam logic [7:0] ADDR_RAW1_HI = 8'h08;
  localparam logic [7:0] ADDR_RAW1_LO = 8'h09;
  localparam logic [7:0] ADDR_RAW2_HI = 8'h0A;
  localparam logic [7:0] ADDR_RAW2_LO = 8'h0B;

  localparam int CFG_SOFT_RESET_BIT_BIT = 7;
  localparam int CFG_INT_BIT = 6;
  localparam int CFG_GAIN_LSB = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_RDY_BIT = 1;
  localparam int CFG_FACTORY_RESTORE_BIT = 0;
  localparam int LED_ERR_BIT = 7;
  localparam int LED_ILLUM_CUR_LSB = 4;
  localparam int LED_ILLUM_EN_BIT = 3;
  localparam int LED_IND_CUR_LSB = 1;
  localparam int LED_IND_EN_BIT = 0;

  localparam logic [7:0] FW_SEL_MAJOR = 8'h01;
  localparam logic [7:0] FW_SEL_PATCH = 8'h02;
  localparam logic [7:0] FW_SEL_BUILD = 8'h03;
  localparam logic [7:0] FW_SEL_RESET = 8'h00;

  typedef enum logic [1:0] {
    GAIN_1X = 2'b00, GAIN_3X7 = 2'b01, GAIN_16X = 2'b10, GAIN_64X = 2'b11
  } gain_type;
  typedef enum logic [1:0] {
    MODE_FOUR_A = 2'b00, MODE_FOUR_B = 2'b01,
    MODE_ALL_SIX = 2'b10, MODE_ONE_SHOT = 2'b11
  } mode_type;
  typedef enum logic [1:0] {
    ILLUM_12MA5 = 2'b00, ILLUM_25MA = 2'b01,
    ILLUM_50MA = 2'b10, ILLUM_100MA = 2'b11
  } illum_cur_type;
  typedef enum logic [1:0] {
    IND_1MA = 2'b00, IND_2MA = 2'b01, IND_4MA = 2'b10, IND_8MA = 2'b11
  } ind_cur_type;

  typedef struct packed {
    illum_cur_type illum_drive_current;
    logic illum_drive_enable;
    ind_cur_type indicator_current;
    logic indicator_enable;
  } led_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
    logic [7:0] temp;
    logic temp_ok;
  } chip_data_type;

  localparam led_cfg_type LED_CFG_RESET = '{ILLUM_12MA5, 1'b0, IND_2MA, 1'b0};
  localparam gain_type GAIN_RESET = GAIN_3X7;
  localparam mode_type MODE_RESET = MODE_ALL_SIX;
  localparam logic [7:0] INTEG_RESET = 8'h20;
  localparam logic [7:0] TEMP_ERROR = 8'h80;
  localparam logic [18:0] COUNTS_PER_CYCLE = 19'h00400;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam real CLK_PERIOD_NS = 10.0;
  localparam real INTEG_CYCLE_MS = 2.78;
  localparam int INTEG_CYCLE_CLKS = int'(INTEG_CYCLE_MS * 1.0e6 / CLK_PERIOD_NS);

  // highest count reachable after period+1 integration cycles
  function automatic logic [15:0] max_count(input logic [7:0] period);
    logic [18:0] full;
    full = ({11'h000, period} + 19'h00001) * COUNTS_PER_CYCLE - 19'h00001;
    if (full > {3'h0, COUNT_MAX}) begin
      return COUNT_MAX;
    end
    return full[15:0];
  endfunction

endpackage

// >>> logic/integ_timer.sv
// integration timer: period+1 cycles of a fixed length each
// assumes start arrives only while idle
module integ_timer import spectral_pkg::*; #(
  parameter int CYCLE_CLKS = INTEG_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] period,
  output logic busy,
  output logic done
);

  if (CYCLE_CLKS < 1) begin : g_check
    $error("integ_timer: CYCLE_CLKS must be at least one");
  end

  localparam int DW = (CYCLE_CLKS > 1) ? $clog2(CYCLE_CLKS) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(CYCLE_CLKS - 1);

  logic [DW-1:0] div_reg;
  logic [8:0] left_reg;
  logic tick;

  assign tick = busy && (div_reg == DIV_LAST);

  always_ff @(posedge clk) begin
    if (rst || start || tick) begin
      div_reg <= '0;
    end else if (busy) begin
      div_reg <= div_reg + DW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      left_reg <= 9'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        left_reg <= {1'b0, period} + 9'h001; // see R6
      end else if (tick) begin
        left_reg <= left_reg - 9'h001;
        if (left_reg == 9'h001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> logic/result_mem.sv
// small result store, one word per chip and channel
// assumes one write port, one read port, read data one cycle late
module result_mem import spectral_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 6
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("result_mem: unsupported geometry");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> logic/spectral_sensor_reg_bank.sv
// host-visible register bank of a chained multi-chip spectral sensor
// assumes byte register requests synchronous to clk, front-end data held
//
// Summary of operation
// R1 - host writes selector 1..3, reads high byte of chosen version part
// R2 - writing soft reset bit resets device; reading it gives gain error
// R3 - gain field bits 5:4 selects 1x, 3.7x, 16x, 64x; resets to 01
// R4 - mode field bits 3:2: two four-channel modes, continuous six; reset 10
// R5 - mode code 11 performs one single six-channel measurement pass
// R6 - integration lasts period+1 cycles of 2.78 ms; max count saturates
// R7 - host programs 64 cycles or more for full sixteen-bit range
// R8 - temperature is signed Celsius; -128 signals a failed reading
// R9 - temperature comes from the chip chosen by target chip select
// R10 - illumination current bits 5:4 per selected chip, 12.5 to 100 mA
// R11 - indicator current bits 2:1 reset 01; bits 3, 0 enable drivers
// R12 - LED config bit 7 is read-only flag for status read error
// R13 - first raw pair: sixteen-bit count, high byte first, selected chip
// R14 - second raw pair: read-only count, high byte first, selected chip
// R15 - data-ready bit 1 set on new result; drives interrupt when enabled
// R16 - factory restore bit 0 returns settings to defaults; reads zero
module spectral_sensor_reg_bank import spectral_pkg::*; #(
  parameter int NUM_CHIPS = 3,
  parameter int CYCLE_CLKS = INTEG_CYCLE_CLKS,
  parameter logic [7:0] HW_DEVICE_TYPE = 8'h5A, // arbitrary value
  parameter logic [7:0] HW_REVISION = 8'h01 // arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [1:0] target_chip_select,
  input wire logic [15:0] fw_major,
  input wire logic [15:0] fw_patch,
  input wire logic [15:0] fw_build,
  input wire logic gain_error,
  input wire logic status_read_err,
  input chip_data_type [NUM_CHIPS-1:0] chip_data,
  output gain_type gain_sel,
  output mode_type meas_mode,
  output logic integrating,
  output logic int_pin,
  output logic device_reset,
  output led_cfg_type [NUM_CHIPS-1:0] led_cfg
);

  if (NUM_CHIPS < 1 || NUM_CHIPS > 4) begin : g_check
    $error("spectral_sensor_reg_bank: NUM_CHIPS must be 1 to 4");
  end

  localparam int ENTRIES = 2 * NUM_CHIPS;
  localparam int AW = $clog2(ENTRIES);
  localparam logic [AW-1:0] LAST_ENTRY = AW'(ENTRIES - 1);
  localparam logic [1:0] CHIP_LIMIT = 2'(NUM_CHIPS - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INTEG = 2'b01,
    ST_CAPTURE = 2'b10
  } meas_state_type;

  // memory slot of one channel of one chip
  function automatic logic [AW-1:0] slot(input logic [1:0] chip,
                                         input logic second);
    logic [3:0] s;
    s = {1'b0, chip, 1'b0} + {3'h0, second};
    return s[AW-1:0];
  endfunction

  logic rst_all;
  logic wr_cfg;
  logic wr_led;
  logic factory_hit;
  logic sel_ok;
  logic rd_take;
  logic [AW-1:0] mem_rd_addr;
  logic [15:0] mem_rd_data;
  logic [15:0] cap_value;
  logic [15:0] cap_raw;
  logic cap_wr;
  logic timer_done;
  logic timer_start;

  meas_state_type state_reg;
  meas_state_type state_next;
  logic soft_rst_reg;
  logic [7:0] fw_sel_reg;
  logic int_en_reg;
  logic rdy_reg;
  logic read_err_reg;
  logic one_shot_reg;
  logic [7:0] integ_reg;
  logic [7:0] run_period_reg;
  logic [AW-1:0] cap_idx_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;

  // soft reset reaches every register except its own strobe, device_reset and the result memory
  assign rst_all = sys_rst || soft_rst_reg;
  assign sel_ok = target_chip_select <= CHIP_LIMIT;
  assign wr_cfg = reg_req.wr && (reg_req.addr == ADDR_CFG);
  assign wr_led = reg_req.wr && (reg_req.addr == ADDR_LED);
  assign factory_hit = wr_cfg && reg_req.wdata[CFG_FACTORY_RESTORE_BIT];
  assign rd_take = reg_req.rd && !reg_req.wr;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_cfg && reg_req.wdata[CFG_SOFT_RESET_BIT_BIT]; // see R2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= wr_cfg && reg_req.wdata[CFG_SOFT_RESET_BIT_BIT]; // see R2
    end
  end

  // version selector
  always_ff @(posedge clk) begin
    if (rst_all) begin
      fw_sel_reg <= FW_SEL_RESET;
    end else if (reg_req.wr && (reg_req.addr == ADDR_FW_HI ||
                                reg_req.addr == ADDR_FW_LO)) begin
      fw_sel_reg <= reg_req.wdata; // see R1
    end
  end

  // measurement configuration
  always_ff @(posedge clk) begin
    if (rst_all || factory_hit) begin
      int_en_reg <= 1'b0; // see R16
      gain_sel <= GAIN_RESET; // see R3
      meas_mode <= MODE_RESET; // see R4
    end else if (wr_cfg) begin
      int_en_reg <= reg_req.wdata[CFG_INT_BIT];
      gain_sel <= gain_type'(reg_req.wdata[CFG_GAIN_LSB +: 2]); // see R3
      meas_mode <= mode_type'(reg_req.wdata[CFG_MODE_LSB +: 2]); // see R4
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all || factory_hit) begin
      integ_reg <= INTEG_RESET; // see R16
    end else if (reg_req.wr && reg_req.addr == ADDR_INTEG) begin
      integ_reg <= reg_req.wdata; // see R6
    end
  end

  // per-chip light source settings, written through the selected chip
  for (genvar c = 0; c < NUM_CHIPS; c++) begin : g_led
    always_ff @(posedge clk) begin
      if (rst_all || factory_hit) begin
        led_cfg[c] <= LED_CFG_RESET; // see R11
      end else if (wr_led && target_chip_select == 2'(c)) begin
        led_cfg[c].illum_drive_current <=
          illum_cur_type'(reg_req.wdata[LED_ILLUM_CUR_LSB +: 2]); // see R10
        led_cfg[c].illum_drive_enable <=
          reg_req.wdata[LED_ILLUM_EN_BIT]; // see R11
        led_cfg[c].indicator_current <=
          ind_cur_type'(reg_req.wdata[LED_IND_CUR_LSB +: 2]); // see R11
        led_cfg[c].indicator_enable <=
          reg_req.wdata[LED_IND_EN_BIT]; // see R11
      end
    end
  end

  // sticky status-read error; a new error wins over the read that clears
  always_ff @(posedge clk) begin
    if (rst_all) begin
      read_err_reg <= 1'b0;
    end else if (status_read_err) begin
      read_err_reg <= 1'b1; // see R12
    end else if (rd_pend_reg && rd_addr_reg == ADDR_LED) begin
      read_err_reg <= 1'b0;
    end
  end

  // one-shot request armed by writing mode 11, consumed at start
  always_ff @(posedge clk) begin
    if (rst_all) begin
      one_shot_reg <= 1'b0;
    end else if (wr_cfg && !factory_hit && reg_req.wdata[CFG_MODE_LSB +: 2]
                 == MODE_ONE_SHOT) begin
      one_shot_reg <= 1'b1; // see R5
    end else if (timer_start) begin
      one_shot_reg <= 1'b0;
    end
  end

  // measurement sequencing
  always_comb begin
    state_next = state_reg;
    timer_start = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (meas_mode != MODE_ONE_SHOT || one_shot_reg) begin
          timer_start = 1'b1; // see R5
          state_next = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (timer_done) begin
          state_next = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (cap_idx_reg == LAST_ENTRY) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // period frozen for the whole pass so saturation matches the timer
  always_ff @(posedge clk) begin
    if (rst_all) begin
      run_period_reg <= INTEG_RESET;
    end else if (timer_start) begin
      run_period_reg <= integ_reg; // see R6
    end
  end

  integ_timer #(
    .CYCLE_CLKS(CYCLE_CLKS)
  ) u_timer (
    .clk(clk),
    .rst(rst_all),
    .start(timer_start),
    .period(integ_reg),
    .busy(integrating),
    .done(timer_done)
  );

  // capture walks one slot per cycle: chip 0 first, then second
  always_ff @(posedge clk) begin
    if (rst_all || state_reg != ST_CAPTURE) begin
      cap_idx_reg <= '0;
    end else if (cap_idx_reg != LAST_ENTRY) begin
      cap_idx_reg <= cap_idx_reg + AW'(1);
    end
  end

  assign cap_wr = (state_reg == ST_CAPTURE);

  always_comb begin
    cap_raw = 16'h0000;
    for (int i = 0; i < ENTRIES; i++) begin
      if (cap_idx_reg == AW'(i)) begin
        cap_raw = (i % 2 == 0) ? chip_data[i / 2].first
                               : chip_data[i / 2].second;
      end
    end
  end

  // counts cannot exceed what the integration length allows
  assign cap_value = (cap_raw > max_count(run_period_reg)) ?
                     max_count(run_period_reg) : cap_raw; // see R6

  // a completed pass wins over the read that clears the flag
  always_ff @(posedge clk) begin
    if (rst_all) begin
      rdy_reg <= 1'b0;
    end else if (cap_wr && cap_idx_reg == LAST_ENTRY) begin
      rdy_reg <= 1'b1; // see R15
    end else if (rd_take && reg_req.addr == ADDR_RAW1_HI) begin
      rdy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      int_pin <= 1'b0;
    end else begin
      int_pin <= int_en_reg && rdy_reg; // see R15
    end
  end

  // read address decides the slot; out-of-range chip reads chip 0
  assign mem_rd_addr = slot(sel_ok ? target_chip_select : 2'b00,
                            reg_req.addr == ADDR_RAW2_HI ||
                            reg_req.addr == ADDR_RAW2_LO); // see R13 R14

  result_mem #(
    .WIDTH(16),
    .DEPTH(ENTRIES)
  ) u_results (
    .clk(clk),
    .wr_en(cap_wr),
    .wr_addr(cap_idx_reg),
    .wr_data(cap_value),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  always_ff @(posedge clk) begin
    if (rst_all) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
    end else begin
      rd_pend_reg <= rd_take;
      rd_addr_reg <= reg_req.addr;
    end
  end

  // read data assembled in the second cycle, when memory data is valid
  always_ff @(posedge clk) begin
    if (rst_all) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      reg_rdata <= 8'h00;
    end else if (rd_pend_reg) begin
      unique case (rd_addr_reg)
        ADDR_HW_HI: reg_rdata <= HW_DEVICE_TYPE;
        ADDR_HW_LO: reg_rdata <= HW_REVISION;
        ADDR_FW_HI, ADDR_FW_LO: begin
          unique case (fw_sel_reg)
            FW_SEL_MAJOR: reg_rdata <= fw_major[15:8]; // see R1
            FW_SEL_PATCH: reg_rdata <= fw_patch[15:8]; // see R1
            FW_SEL_BUILD: reg_rdata <= fw_build[15:8]; // see R1
            default: reg_rdata <= 8'h00;
          endcase
        end
        ADDR_CFG: begin
          reg_rdata <= {gain_error, int_en_reg, gain_sel, meas_mode,
                        rdy_reg, 1'b0}; // see R2 R15 R16
        end
        ADDR_INTEG: reg_rdata <= integ_reg;
        ADDR_TEMP: begin
          if (!sel_ok) begin
            reg_rdata <= TEMP_ERROR; // see R8
          end else if (!chip_data[target_chip_select].temp_ok ||
                       chip_data[target_chip_select].temp == TEMP_ERROR)
          begin
            reg_rdata <= TEMP_ERROR; // see R8
          end else begin
            reg_rdata <= chip_data[target_chip_select].temp; // see R9
          end
        end
        ADDR_LED: begin
          if (sel_ok) begin
            reg_rdata <= {read_err_reg, 1'b0,
                          led_cfg[target_chip_select]}; // see R10 R11 R12
          end else begin
            reg_rdata <= {read_err_reg, 7'h00}; // see R12
          end
        end
        ADDR_RAW1_HI, ADDR_RAW2_HI: begin
          reg_rdata <= mem_rd_data[15:8]; // see R13 R14
        end
        ADDR_RAW1_LO, ADDR_RAW2_LO: begin
          reg_rdata <= mem_rd_data[7:0]; // see R13 R14
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// >>> verif/host_model.sv
// host controller model issuing byte register requests
// assumes the bank answers a read within four cycles
module host_model import spectral_pkg::*; (
  input wire logic clk,
  output reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req = '0;

  // held from one falling edge to the next, spanning one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{a, d, 1'b1, 1'b0};
    @(negedge clk);
    reg_req = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    reg_req = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge clk);
    reg_req = '0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule

// >>> verif/spectral_sensor_reg_bank_checker.sv
// port-level assertions on the sensor register bank
// assumes it is bound into every instance of the bank
module spectral_sensor_reg_bank_checker import spectral_pkg::*; #(
  parameter int NUM_CHIPS = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [1:0] target_chip_select,
  input wire logic [15:0] fw_major,
  input wire logic [15:0] fw_patch,
  input wire logic [15:0] fw_build,
  input wire logic gain_error,
  input wire logic status_read_err,
  input chip_data_type [NUM_CHIPS-1:0] chip_data,
  input gain_type gain_sel,
  input mode_type meas_mode,
  input wire logic integrating,
  input wire logic int_pin,
  input wire logic device_reset,
  input led_cfg_type [NUM_CHIPS-1:0] led_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_take;
  logic cfg_wr;
  logic led_wr;
  assign rd_take = reg_req.rd && !reg_req.wr;
  assign cfg_wr = reg_req.wr && reg_req.addr == ADDR_CFG;
  assign led_wr = reg_req.wr && reg_req.addr == ADDR_LED;
  // soft reset drops requests in flight, so that cycle is not judged
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || device_reset);

  a_read_latency: assert property (rd_take |-> ##2 reg_rvalid)
    else $error("read answer not two cycles after request");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(rd_take, 2))
    else $error("read answer without a request");
  a_gain_write: assert property (cfg_wr && !reg_req.wdata[7]
      && !reg_req.wdata[0] |=> gain_sel == $past(reg_req.wdata[5:4]))
    else $error("gain field not taken from write");
  a_mode_write: assert property (cfg_wr && reg_req.wdata[7:6] == 2'h0
      && !reg_req.wdata[0] ##1 1'b1 |-> meas_mode == $past(reg_req.wdata[3:2]))
    else $error("mode field not taken from write");
  a_restore_defaults: assert property (cfg_wr && reg_req.wdata[0]
      && !reg_req.wdata[7] |=> gain_sel == GAIN_RESET
      && meas_mode == MODE_RESET && led_cfg[0] == LED_CFG_RESET)
    else $error("factory restore left settings changed");
  a_soft_reset_pulse: assert property (disable iff (sys_rst)
      cfg_wr && reg_req.wdata[7] |=> device_reset ##1 !device_reset)
    else $error("soft reset pulse missing or too long");
  a_reset_defaults: assert property (disable iff (sys_rst)
      device_reset |=> gain_sel == GAIN_RESET && meas_mode == MODE_RESET
      && !integrating && !reg_rvalid && !int_pin)
    else $error("soft reset did not restore defaults");
  a_led_write: assert property (led_wr && target_chip_select == 2'h0
      |=> led_cfg[0] == $past(reg_req.wdata[5:0]))
    else $error("light source write not applied to chosen chip");
  a_led_other_hold: assert property (led_wr
      && target_chip_select != 2'h1 |=> $stable(led_cfg[1]))
    else $error("light source write reached an unchosen chip");
  a_cfg_read: assert property (rd_take && reg_req.addr == ADDR_CFG
      |-> ##2 reg_rvalid && !reg_rdata[0]
      && reg_rdata[5:2] == {$past(gain_sel, 2), $past(meas_mode, 2)})
    else $error("configuration read back wrong");

  cover property (rd_take ##2 reg_rvalid);
  cover property ($rose(int_pin));
  cover property ($fell(integrating));
  cover property (disable iff (sys_rst) device_reset);
endmodule

bind spectral_sensor_reg_bank spectral_sensor_reg_bank_checker #(
  .NUM_CHIPS(NUM_CHIPS)) checker_i (.clk(clk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .target_chip_select(target_chip_select), .fw_major(fw_major),
  .fw_patch(fw_patch), .fw_build(fw_build), .gain_error(gain_error),
  .status_read_err(status_read_err), .chip_data(chip_data),
  .gain_sel(gain_sel), .meas_mode(meas_mode), .integrating(integrating),
  .int_pin(int_pin), .device_reset(device_reset), .led_cfg(led_cfg));

// >>> verif/tb_spectral_sensor_reg_bank.sv
// self-checking bench of the sensor register bank with a host model
// assumes 100 MHz clock and a shortened integration cycle
module tb_spectral_sensor_reg_bank import spectral_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHIPS = 3;
  localparam logic [7:0] DEV_TYPE = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV_REV = 8'hC5; // arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_type reg_req;
  logic [7:0] reg_rdata;
  logic [7:0] rd_val;
  logic reg_rvalid;
  logic integrating;
  logic int_pin;
  logic device_reset;
  logic [1:0] target_chip_select = 2'h0;
  logic [15:0] fw_major = 16'hA1B2;
  logic [15:0] fw_patch = 16'hC3D4;
  logic [15:0] fw_build = 16'hE5F6;
  logic gain_error = 1'b0;
  logic status_read_err = 1'b0;
  chip_data_type [CHIPS-1:0] chip_data;
  gain_type gain_sel;
  mode_type meas_mode;
  led_cfg_type [CHIPS-1:0] led_cfg;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  spectral_sensor_reg_bank #(.NUM_CHIPS(CHIPS), .CYCLE_CLKS(4),
    .HW_DEVICE_TYPE(DEV_TYPE), .HW_REVISION(DEV_REV))
    spectral_sensor_reg_bank_i (.clk(clk),
    .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .target_chip_select(target_chip_select),
    .fw_major(fw_major), .fw_patch(fw_patch), .fw_build(fw_build),
    .gain_error(gain_error), .status_read_err(status_read_err),
    .chip_data(chip_data), .gain_sel(gain_sel), .meas_mode(meas_mode),
    .integrating(integrating), .int_pin(int_pin),
    .device_reset(device_reset), .led_cfg(led_cfg));
  host_model host_model_i (.clk(clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    host_model_i.rd(a, rd_val);
    check({8'h00, rd_val & m}, {8'h00, e});
  endtask

  function automatic logic [15:0] sat(input logic [15:0] v,
      input logic [7:0] p);
    logic [18:0] m;
    m = (19'(p) + 19'h00001) * 19'h00400 - 19'h00001;
    m = (m > 19'h0FFFF) ? 19'h0FFFF : m;
    return (v > m[15:0]) ? m[15:0] : v;
  endfunction

  task automatic t_reset_values();
    rc(ADDR_CFG, 8'hFF, 8'h18);
    rc(ADDR_INTEG, 8'hFF, 8'h20);
    rc(ADDR_LED, 8'hFF, 8'h02);
    rc(ADDR_HW_HI, 8'hFF, DEV_TYPE);
    rc(ADDR_HW_LO, 8'hFF, DEV_REV);
    rc(ADDR_FW_LO, 8'hFF, 8'h00);
    rc(8'h40, 8'hFF, 8'h00);
  endtask

  task automatic t_fw_select();
    logic [15:0] v [3];
    v = '{fw_major, fw_patch, fw_build};
    for (int s = 1; s <= 3; s++) begin
      host_model_i.wr(s[0] ? ADDR_FW_HI : ADDR_FW_LO, 8'(s));
      rc(ADDR_FW_HI, 8'hFF, v[s-1][15:8]);
      rc(ADDR_FW_LO, 8'hFF, v[s-1][15:8]);
    end
  endtask

  // data-ready is masked here: a pass may finish at any time
  task automatic t_cfg_fields();
    gain_error = 1'b1;
    for (int g = 0; g < 4; g++) begin
      host_model_i.wr(ADDR_CFG, {2'b00, 2'(g), 2'(3 - g), 2'b00});
      rc(ADDR_CFG, 8'hFD, {2'b10, 2'(g), 2'(3 - g), 2'b00});
      check(16'(gain_sel), 16'(g));
      check(16'(meas_mode), 16'(3 - g));
    end
    host_model_i.wr(ADDR_INTEG, 8'h55);
    host_model_i.wr(ADDR_LED, 8'h3F);
    host_model_i.wr(ADDR_CFG, 8'h71);
    rc(ADDR_CFG, 8'hFD, 8'h98);
    rc(ADDR_INTEG, 8'hFF, 8'h20);
    rc(ADDR_LED, 8'hFF, 8'h02);
    gain_error = 1'b0;
  endtask

  task automatic t_led_temp();
    logic [7:0] led [3] = '{8'h39, 8'h1C, 8'h25};
    logic [7:0] tmp [3] = '{8'h19, 8'h80, 8'hF6};
    for (int c = 0; c < 3; c++) begin
      target_chip_select = 2'(c);
      host_model_i.wr(ADDR_LED, 8'hC0 | led[c]);
    end
    for (int c = 0; c < 3; c++) begin
      target_chip_select = 2'(c);
      rc(ADDR_LED, 8'hFF, led[c]);
      check(16'(led_cfg[c]), 16'(led[c][5:0]));
      rc(ADDR_TEMP, 8'hFF, tmp[c]);
    end
    target_chip_select = 2'h3;
    rc(ADDR_TEMP, 8'hFF, 8'h80);
    target_chip_select = 2'h0;
    @(negedge clk);
    status_read_err = 1'b1;
    @(negedge clk);
    status_read_err = 1'b0;
    rc(ADDR_LED, 8'hFF, 8'hB9);
    rc(ADDR_LED, 8'hFF, 8'h39);
  endtask

  task automatic t_soft_reset();
    host_model_i.wr(ADDR_CFG, 8'h38);
    host_model_i.wr(ADDR_CFG, 8'h80);
    repeat (2) @(negedge clk);
    rc(ADDR_LED, 8'hFF, 8'h02);
    rc(ADDR_CFG, 8'hFD, 8'h18);
  endtask

  task automatic t_measure(input logic [7:0] p);
    int n;
    int q;
    logic [15:0] f;
    logic [15:0] s;
    n = 0;
    q = 0;
    host_model_i.wr(ADDR_CFG, 8'h1C);
    while (q < 30 && n < 2000) begin
      @(negedge clk);
      q = integrating ? 0 : q + 1;
      n++;
    end
    check(16'(q), 16'd30);
    host_model_i.rd(ADDR_RAW1_HI, rd_val);
    host_model_i.wr(ADDR_INTEG, p);
    host_model_i.wr(ADDR_CFG, 8'h5C);
    n = 0;
    while (int_pin !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(16'(int_pin), 16'h0001);
    check(16'(integrating), 16'h0000);
    rc(ADDR_CFG, 8'hFF, 8'h5E);
    for (int c = 0; c < 3; c++) begin
      target_chip_select = 2'(c);
      f = sat(chip_data[c].first, p);
      s = sat(chip_data[c].second, p);
      rc(ADDR_RAW1_HI, 8'hFF, f[15:8]);
      rc(ADDR_RAW1_LO, 8'hFF, f[7:0]);
      rc(ADDR_RAW2_HI, 8'hFF, s[15:8]);
      rc(ADDR_RAW2_LO, 8'hFF, s[7:0]);
    end
    target_chip_select = 2'h0;
    check(16'(int_pin), 16'h0000);
  endtask

  initial begin
    chip_data[0] = '{16'hFFFF, 16'h0123, 8'h19, 1'b1};
    chip_data[1] = '{16'h0100, 16'hFFFF, 8'h7F, 1'b0};
    chip_data[2] = '{16'h0400, 16'h0002, 8'hF6, 1'b1};
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset_values();
    t_fw_select();
    t_cfg_fields();
    t_led_temp();
    t_soft_reset();
    t_measure(8'h00);
    t_measure(8'h3F);
    test_done();
  end
endmodule
